// ---- core/icp_ahb_slave.sv ----
// AHB-Lite slave front end: captures the address phase and gives one-cycle access strobes
`timescale 1ns/100ps
module icp_ahb_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic wr_en,
	output logic rd_en,
	output logic [31:0] acc_addr
);
	logic wr_q;
	logic rd_q;
	logic [31:0] addr_q;
	wire take = hsel && hready && htrans[1] && (hsize == 3'h2);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			if (take)
				addr_q <= haddr;
		end
	end

	// Zero wait states; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr_en = wr_q;
	assign rd_en = rd_q;
	assign acc_addr = addr_q;
endmodule

// ---- core/icp_edge_latch.sv ----
// Latency shaper: delays pin-type events by a fixed number of instruction cycles
`timescale 1ns/100ps
module icp_edge_latch #(
	parameter int STAGES = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic event_in,
	output logic event_out
);
	logic [STAGES-1:0] pipe_q;

	// A short pipe gives pin and port-change events their extra cycles before the flag rises
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pipe_q <= '0;
		else
			pipe_q <= {pipe_q[STAGES-2:0], event_in};
	end

	assign event_out = pipe_q[STAGES-1];
endmodule

// ---- core/icp_irq_ctrl.sv ----
// Interrupt collection, vectoring and power-down entry for the 8-bit core
//
// Summary of operation
// - Up to 14 sources, each with a latched flag and its own mask bit.
// - A flag sets on its event regardless of mask or global enable.
// - irq_control bit 7 is global enable; clear means no interrupt taken.
// - Global enable plus flag plus mask (plus irq_control bit 6 for peripherals) raises the vector request at once.
// - Every reset clears the global enable.
// - Return-from-interrupt leaves the routine and sets global enable again.
// - Edge pin, port-change and timer-zero flags and enables live in irq_control.
// - Peripheral flags in two flag registers, masks in two enable registers.
// - On acceptance: clear global enable, push return address, load PC 0004h.
// - Pin and port-change event to vector takes three or four cycles.
// - Power-down is entered only by the sleep instruction.
// - Sleep clears watchdog, clears power_down_flag, sets wdt_expiry_flag, stops oscillator.
// - In power-down every pin keeps its drive state.
// - An interrupt wakes the device only if its enable bit is set.
// - Wake ignores global enable; if set, next instruction runs then vectors.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module icp_irq_ctrl #(
	parameter int N_PERIPH = icp_pkg::ICP_N_PERIPH,
	parameter int PIN_STAGES = icp_pkg::ICP_SYNC_CYCLES,
	parameter int N_IO = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire icp_pkg::icp_src_t src_events,
	input wire icp_pkg::icp_core_t core_ctl,
	input wire logic [15:0] return_addr,
	input wire logic [N_IO-1:0] io_out,
	input wire logic [N_IO-1:0] io_oe,
	output logic [N_IO-1:0] pin_out,
	output logic [N_IO-1:0] pin_oe,
	output logic vector_req,
	output logic [15:0] vector_addr,
	output logic stack_push,
	output logic [15:0] stack_data,
	output logic wdt_clear,
	output logic osc_stop,
	output logic wake,
	output logic irq
);
	import icp_pkg::*;

	logic wr_en;
	logic rd_en;
	logic [31:0] acc_addr;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] flags_one_q;
	logic [7:0] flags_two_q;
	logic [7:0] enables_one_q;
	logic [7:0] enables_two_q;
	logic [7:0] status_q;
	logic [ICP_N_EVT-1:0] evt_q;
	logic [ICP_N_EVT-1:0] evt_mask_q;
	logic [ICP_N_EVT-1:0] evt_set;
	logic [15:0] vec_q;
	logic stack_push_q;
	logic [15:0] stack_data_q;
	logic wdt_clear_q;
	logic [N_IO-1:0] hold_out_q;
	logic [N_IO-1:0] hold_oe_q;
	logic [7:0] rd_sel;
	logic [1:0] pin_dly;
	logic ext_dly;
	logic port_dly;
	icp_state_t state_q;
	icp_state_t state_d;

	// One decoder for the write strobes and the read mux keeps the map in one place
	function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
	begin
		reg_hit = (addr == reg_addr);
	end
	endfunction

	icp_ahb_slave u_bus (
		.clk(clk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.acc_addr(acc_addr)
	);

	// Pin-type events pass a short pipe so the vector follows three to four cycles later
	// Bit 1 carries the edge pin, bit 0 the port-change detector
	wire [1:0] pin_ev = {src_events.ext_edge, src_events.port_change};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			icp_edge_latch #(.STAGES(PIN_STAGES - 1)) u_dly (
				.clk(clk),
				.rst(rst),
				.event_in(pin_ev[gi]),
				.event_out(pin_dly[gi])
			);
		end
	endgenerate

	assign ext_dly = pin_dly[1];
	assign port_dly = pin_dly[0];

	wire wr_ctrl = wr_en && reg_hit(acc_addr, ICP_ADDR_IRQ_CONTROL);
	wire wr_flags_one = wr_en && reg_hit(acc_addr, ICP_ADDR_FLAGS_ONE);
	wire wr_flags_two = wr_en && reg_hit(acc_addr, ICP_ADDR_FLAGS_TWO);
	wire wr_enables_one = wr_en && reg_hit(acc_addr, ICP_ADDR_ENABLES_ONE);
	wire wr_enables_two = wr_en && reg_hit(acc_addr, ICP_ADDR_ENABLES_TWO);
	wire wr_evt = wr_en && reg_hit(acc_addr, ICP_ADDR_EVT_STAT);
	wire wr_emask = wr_en && reg_hit(acc_addr, ICP_ADDR_EVT_MASK);

	// Peripheral events spread over the two flag registers, low eight first
	wire [15:0] periph_ev = {{(16 - N_PERIPH){1'b0}}, src_events.periph};
	wire [7:0] flags_one_ev = periph_ev[7:0];
	wire [7:0] flags_two_ev = periph_ev[15:8];

	wire glb_en = ctrl_q[ICP_GLB_EN_BIT];
	wire [7:0] core_pend = {5'h00, ctrl_q[ICP_TMR_FLAG_BIT], ctrl_q[ICP_EDGE_FLAG_BIT], ctrl_q[ICP_PORT_FLAG_BIT]};
	wire [7:0] core_en = {5'h00, ctrl_q[ICP_TMR_EN_BIT], ctrl_q[ICP_EDGE_EN_BIT], ctrl_q[ICP_PORT_EN_BIT]};
	wire core_hit = |(core_pend & core_en);
	wire periph_hit = |((flags_one_q & enables_one_q) | (flags_two_q & enables_two_q));
	// Wake needs the source's own enable, plus irq_control bit 6 for peripherals; global enable is not consulted
	wire wake_cond = core_hit || (ctrl_q[ICP_GRP_EN_BIT] && periph_hit);
	wire take_irq = glb_en && wake_cond;

	// Sleep is honoured only as an instruction; with wake pending it completes as a no-op
	// so software can tell from the power-down flag whether it really slept
	wire sleep_go = core_ctl.instr_sleep && (state_q == ICP_RUN) && !(take_irq || (wake_cond && !glb_en));
	wire accept = take_irq && (state_q == ICP_RUN) && core_ctl.instr_end;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ICP_RUN:
				if (sleep_go)
					state_d = ICP_ASLEEP;
			ICP_ASLEEP:
				if (wake_cond)
					state_d = ICP_WAKE_NEXT;
			ICP_WAKE_NEXT:
				if (core_ctl.instr_end)
					state_d = ICP_RUN;
			default:
				state_d = ICP_RUN;
		endcase
	end

	// Flag updates: software writes first, hardware events then OR in so a set wins
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = hwdata[7:0];
		if (accept)
			ctrl_d[ICP_GLB_EN_BIT] = 1'b0;
		else if (core_ctl.instr_return)
			ctrl_d[ICP_GLB_EN_BIT] = 1'b1;
		ctrl_d[ICP_TMR_FLAG_BIT] = ctrl_d[ICP_TMR_FLAG_BIT] | src_events.timer_zero;
		ctrl_d[ICP_EDGE_FLAG_BIT] = ctrl_d[ICP_EDGE_FLAG_BIT] | ext_dly;
		ctrl_d[ICP_PORT_FLAG_BIT] = ctrl_d[ICP_PORT_FLAG_BIT] | port_dly;
	end

	assign evt_set = {wake && (state_q == ICP_ASLEEP), sleep_go, accept};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_q <= ICP_CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flags_one_q <= ICP_PIR_RESET;
			flags_two_q <= ICP_PIR_RESET;
		end
		else
		begin
			flags_one_q <= (wr_flags_one ? hwdata[7:0] : flags_one_q) | flags_one_ev;
			flags_two_q <= (wr_flags_two ? hwdata[7:0] : flags_two_q) | flags_two_ev;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enables_one_q <= ICP_PIE_RESET;
			enables_two_q <= ICP_PIE_RESET;
		end
		else
		begin
			if (wr_enables_one)
				enables_one_q <= hwdata[7:0];
			if (wr_enables_two)
				enables_two_q <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ICP_RUN;
			status_q <= ICP_STATUS_RESET;
			wdt_clear_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wdt_clear_q <= sleep_go;
			if (sleep_go)
			begin
				status_q[ICP_PWR_DOWN_BIT] <= 1'b0;
				status_q[ICP_WDT_EXP_BIT] <= 1'b1;
			end
		end
	end

	// Vector and return address are registered so the sequencer sees stable data
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			vec_q <= 16'h0000;
			stack_push_q <= 1'b0;
			stack_data_q <= 16'h0000;
		end
		else
		begin
			stack_push_q <= accept;
			if (accept)
			begin
				vec_q <= ICP_IRQ_VECTOR;
				stack_data_q <= return_addr;
			end
		end
	end

	// Pins freeze at the drive state seen when sleep was taken
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hold_out_q <= '0;
			hold_oe_q <= '0;
		end
		else if (state_q == ICP_RUN)
		begin
			hold_out_q <= io_out;
			hold_oe_q <= io_oe;
		end
	end

	// Event status: sticky, write one to clear, hardware set wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			evt_q <= '0;
			evt_mask_q <= '0;
		end
		else
		begin
			evt_q <= (evt_q & ~(wr_evt ? hwdata[ICP_N_EVT-1:0] : '0)) | evt_set;
			if (wr_emask)
				evt_mask_q <= hwdata[ICP_N_EVT-1:0];
		end
	end

	// Unmapped offsets read as zero rather than echo a neighbour
	always_comb
	begin
		rd_sel = 8'h00;
		if (reg_hit(acc_addr, ICP_ADDR_IRQ_CONTROL))
			rd_sel = ctrl_q;
		else if (reg_hit(acc_addr, ICP_ADDR_FLAGS_ONE))
			rd_sel = flags_one_q;
		else if (reg_hit(acc_addr, ICP_ADDR_FLAGS_TWO))
			rd_sel = flags_two_q;
		else if (reg_hit(acc_addr, ICP_ADDR_ENABLES_ONE))
			rd_sel = enables_one_q;
		else if (reg_hit(acc_addr, ICP_ADDR_ENABLES_TWO))
			rd_sel = enables_two_q;
		else if (reg_hit(acc_addr, ICP_ADDR_STATUS))
			rd_sel = status_q;
		else if (reg_hit(acc_addr, ICP_ADDR_EVT_STAT))
			rd_sel = {5'h00, evt_q};
		else if (reg_hit(acc_addr, ICP_ADDR_EVT_MASK))
			rd_sel = {5'h00, evt_mask_q};
	end

	wire [31:0] vec_word = {16'h0000, vec_q};
	wire is_vec = reg_hit(acc_addr, ICP_ADDR_VECTOR);

	assign hrdata = rd_en ? (is_vec ? vec_word : {24'h000000, rd_sel}) : 32'h0000_0000;

	// Vector request is held off while asleep; with global enable set it waits one instruction
	assign vector_req = take_irq && (state_q == ICP_RUN);
	assign vector_addr = vec_q;
	assign stack_push = stack_push_q;
	assign stack_data = stack_data_q;
	assign wdt_clear = wdt_clear_q;
	assign osc_stop = (state_q == ICP_ASLEEP);
	assign wake = (state_q == ICP_ASLEEP) && wake_cond;
	assign pin_out = (state_q == ICP_RUN) ? io_out : hold_out_q;
	assign pin_oe = (state_q == ICP_RUN) ? io_oe : hold_oe_q;
	assign irq = |(evt_q & evt_mask_q);
endmodule

// ---- core/icp_pkg.sv ----
// Package with register map, field positions and types of the interrupt and power-down controller
package icp_pkg;
	localparam logic [31:0] ICP_IDX_IRQ_CONTROL = 32'h0000_000b;
	localparam logic [31:0] ICP_IDX_FLAGS_ONE = 32'h0000_000c;
	localparam logic [31:0] ICP_IDX_ENABLES_ONE = 32'h0000_008c;
	localparam logic [31:0] ICP_ADDR_IRQ_CONTROL = ICP_IDX_IRQ_CONTROL * 4;
	localparam logic [31:0] ICP_ADDR_FLAGS_ONE = ICP_IDX_FLAGS_ONE * 4;
	localparam logic [31:0] ICP_ADDR_ENABLES_ONE = ICP_IDX_ENABLES_ONE * 4;
	localparam logic [31:0] ICP_ADDR_FLAGS_TWO = 32'h0000_0100;
	localparam logic [31:0] ICP_ADDR_ENABLES_TWO = 32'h0000_0104;
	localparam logic [31:0] ICP_ADDR_STATUS = 32'h0000_0108;
	localparam logic [31:0] ICP_ADDR_EVT_STAT = 32'h0000_010c;
	localparam logic [31:0] ICP_ADDR_EVT_MASK = 32'h0000_0110;
	localparam logic [31:0] ICP_ADDR_VECTOR = 32'h0000_0114;
	localparam int ICP_GLB_EN_BIT = 7;
	localparam int ICP_GRP_EN_BIT = 6;
	localparam int ICP_TMR_EN_BIT = 5;
	localparam int ICP_EDGE_EN_BIT = 4;
	localparam int ICP_PORT_EN_BIT = 3;
	localparam int ICP_TMR_FLAG_BIT = 2;
	localparam int ICP_EDGE_FLAG_BIT = 1;
	localparam int ICP_PORT_FLAG_BIT = 0;
	localparam int ICP_PWR_DOWN_BIT = 3;
	localparam int ICP_WDT_EXP_BIT = 4;
	localparam int ICP_N_PERIPH = 11;
	localparam logic [7:0] ICP_CTRL_RESET = 8'h00;
	localparam logic [7:0] ICP_PIR_RESET = 8'h00;
	localparam logic [7:0] ICP_PIE_RESET = 8'h00;
	localparam logic [7:0] ICP_STATUS_RESET = 8'h18;
	localparam logic [15:0] ICP_IRQ_VECTOR = 16'h0004;
	localparam int ICP_SYNC_CYCLES = 3;
	localparam int ICP_EVT_VECTOR = 0;
	localparam int ICP_EVT_SLEEP = 1;
	localparam int ICP_EVT_WAKE = 2;
	localparam int ICP_N_EVT = 3;

	typedef struct packed {
		logic ext_edge;
		logic port_change;
		logic timer_zero;
		logic [ICP_N_PERIPH-1:0] periph;
	} icp_src_t;

	typedef struct packed {
		logic instr_return;
		logic instr_sleep;
		logic instr_end;
	} icp_core_t;

	typedef enum logic [1:0] {
		ICP_RUN,
		ICP_ASLEEP,
		ICP_WAKE_NEXT
	} icp_state_t;
endpackage

// ---- dv/icp_core_model.sv ----
// Behavioural model of the program sequencer beside the controller
`timescale 1ns/100ps
module icp_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic osc_stop,
	input wire logic want_sleep,
	input wire logic want_return,
	output icp_pkg::icp_core_t core_ctl
);
	import icp_pkg::*;
	// Single-cycle instructions only; a stopped oscillator ends nothing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			core_ctl <= '0;
		else
		begin
			core_ctl.instr_end <= !osc_stop;
			core_ctl.instr_sleep <= want_sleep && !osc_stop;
			core_ctl.instr_return <= want_return;
		end
	end
endmodule

// ---- dv/icp_irq_ctrl_assertions.sv ----
// Port-level checks for the interrupt and power-down controller
`timescale 1ns/100ps
module icp_irq_ctrl_assertions #(
	parameter int N_IO = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire icp_pkg::icp_core_t core_ctl,
	input wire logic [15:0] return_addr,
	input wire logic [N_IO-1:0] pin_out,
	input wire logic [N_IO-1:0] pin_oe,
	input wire logic vector_req,
	input wire logic [15:0] vector_addr,
	input wire logic stack_push,
	input wire logic [15:0] stack_data,
	input wire logic wdt_clear,
	input wire logic osc_stop,
	input wire logic wake
);
	import icp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence accept_s;
		vector_req && core_ctl.instr_end;
	endsequence
	sequence sleep_entry_s;
		!osc_stop ##1 osc_stop;
	endsequence
	AST_BUS_OK: assert property (hreadyout && !hresp)
		else $error("bus answer not OKAY");
	AST_PUSH: assert property (accept_s |=> stack_push && stack_data == $past(return_addr))
		else $error("return address not pushed");
	AST_VECTOR: assert property (stack_push |-> vector_addr == 16'h0004)
		else $error("wrong vector");
	AST_GLB_OFF: assert property (accept_s |=> !vector_req)
		else $error("request after accept");
	AST_ONLY_ACCEPT: assert property (stack_push |-> $past(vector_req && core_ctl.instr_end))
		else $error("push without accept");
	AST_SLEEP_CLR: assert property (sleep_entry_s |-> wdt_clear)
		else $error("watchdog not cleared");
	AST_SLEEP_CAUSE: assert property (sleep_entry_s |-> $past(core_ctl.instr_sleep))
		else $error("sleep without instruction");
	AST_HOLD: assert property (osc_stop ##1 osc_stop |-> $stable(pin_out) && $stable(pin_oe))
		else $error("pins moved in sleep");
	AST_WAKE: assert property (wake |=> !osc_stop)
		else $error("no wake");
	AST_ASLEEP_NOVEC: assert property (osc_stop |-> !vector_req)
		else $error("vector while asleep");
endmodule

// ---- dv/icp_irq_ctrl_bench.sv ----
// Self-checking bench for the interrupt and power-down controller
`timescale 1ns/100ps
module icp_irq_ctrl_bench;
	import icp_pkg::*;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, dp = 0, w_sl = 0, w_rf = 0;
	logic hreadyout, hresp, vector_req, stack_push, wdt_clear, osc_stop, wake, irq;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] return_addr = 16'h1234, vector_addr, stack_data;
	logic [7:0] io_out = 0, io_oe = 0, pin_out, pin_oe, held;
	icp_src_t src_events = '0;
	icp_core_t core_ctl;
	logic [31:0] rq[$];
	logic [15:0] pq[$];
	int n_mismatch = 0, comparisons = 0, seed = 96, n;
	icp_irq_ctrl dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .src_events(src_events), .core_ctl(core_ctl), .return_addr(return_addr),
		.io_out(io_out), .io_oe(io_oe), .pin_out(pin_out), .pin_oe(pin_oe), .vector_req(vector_req),
		.vector_addr(vector_addr), .stack_push(stack_push), .stack_data(stack_data),
		.wdt_clear(wdt_clear), .osc_stop(osc_stop), .wake(wake), .irq(irq));
	icp_core_model core_u (.clk(clk), .rst(rst), .osc_stop(osc_stop), .want_sleep(w_sl),
		.want_return(w_rf), .core_ctl(core_ctl));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task results;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task cmp_rd(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task cmp_sig(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			n_mismatch++;
			results;
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, $random(seed));
	endtask
	task pulse(input icp_src_t s);
		src_events <= s;
		@(posedge clk);
		src_events <= '0;
	endtask
	task await_osc(input logic v);
		int i;
		i = 0;
		while (osc_stop !== v && i < 20)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		cmp_sig(osc_stop, v);
		if (i >= 20)
			results;
	endtask
	// Read data is taken at the edge that closes its data phase
	always @(posedge clk)
	begin
		dp <= hsel && htrans[1] && !hwrite;
		if (dp)
			cmp_rd(hrdata, rq.pop_front());
		if (stack_push === 1'b1)
			cmp_sig(stack_data, pq.pop_front());
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		return_addr <= 16'($random(seed));
		@(posedge clk);
		rd(ICP_ADDR_IRQ_CONTROL, 32'h00);
		rd(ICP_ADDR_STATUS, 32'h18);
		rd(ICP_ADDR_FLAGS_ONE, 32'h00);
		rd(ICP_ADDR_ENABLES_ONE, 32'h00);
		pulse(14'h0800);
		rd(ICP_ADDR_IRQ_CONTROL, 32'h04);
		bus(1'b1, ICP_ADDR_ENABLES_ONE, 32'h01);
		pulse(14'h0001);
		bus(1'b1, ICP_ADDR_IRQ_CONTROL, 32'h80);
		#1 cmp_sig(vector_req, 1'b0);
		@(posedge clk);
		pq.push_back(return_addr);
		bus(1'b1, ICP_ADDR_IRQ_CONTROL, 32'hc0);
		rd(ICP_ADDR_IRQ_CONTROL, 32'h40);
		rd(ICP_ADDR_FLAGS_ONE, 32'h01);
		bus(1'b1, ICP_ADDR_FLAGS_ONE, 32'h00);
		w_rf <= 1'b1;
		@(posedge clk);
		w_rf <= 1'b0;
		rd(ICP_ADDR_IRQ_CONTROL, 32'hc0);
		#1 cmp_sig(irq, 1'b0);
		@(posedge clk);
		bus(1'b1, ICP_ADDR_EVT_MASK, 32'h01);
		#1 cmp_sig(irq, 1'b1);
		@(posedge clk);
		bus(1'b1, ICP_ADDR_EVT_STAT, 32'h07);
		#1 cmp_sig(irq, 1'b0);
		@(posedge clk);
		bus(1'b1, ICP_ADDR_IRQ_CONTROL, 32'h90);
		pq.push_back(return_addr);
		pulse(14'h2000);
		n = 1;
		#1;
		while (vector_req !== 1'b1 && n < 9)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_sig(n >= 3 && n <= 4, 1'b1);
		@(posedge clk);
		bus(1'b1, ICP_ADDR_IRQ_CONTROL, 32'h08);
		io_out <= 8'($random(seed));
		io_oe <= 8'($random(seed));
		w_sl <= 1'b1;
		@(posedge clk);
		w_sl <= 1'b0;
		await_osc(1'b1);
		held = pin_out;
		@(posedge clk);
		io_out <= ~io_out;
		rd(ICP_ADDR_STATUS, 32'h10);
		pulse(14'h0800);
		repeat (3) @(posedge clk);
		#1 cmp_sig(wake, 1'b0);
		cmp_sig(pin_out, held);
		@(posedge clk);
		pulse(14'h1000);
		await_osc(1'b0);
		repeat (3) @(posedge clk);
		#1 cmp_sig(vector_req, 1'b0);
		cmp_sig(rq.size() + pq.size(), 32'h0);
		results;
	end
endmodule
bind icp_irq_ctrl icp_irq_ctrl_assertions #(.N_IO(N_IO)) chk_u (.clk(clk), .rst(rst), .hreadyout(hreadyout),
	.hresp(hresp), .core_ctl(core_ctl), .return_addr(return_addr), .pin_out(pin_out), .pin_oe(pin_oe),
	.vector_req(vector_req), .vector_addr(vector_addr), .stack_push(stack_push), .stack_data(stack_data),
	.wdt_clear(wdt_clear), .osc_stop(osc_stop), .wake(wake));
